// ### rtl/ccs_pkg.sv
/*
 Shared constants for the CAN controller SPI command port: instruction codes,
 register map addresses, reset values, flag positions and host timing.
 Assumes an 8-bit register address space decoded as column and row nibbles.
*/
package ccs_pkg;

	// Instruction bytes
	localparam logic [7:0] INSTR_RESET = 8'hc0;
	localparam logic [7:0] INSTR_READ = 8'h03;
	localparam logic [7:0] INSTR_WRITE = 8'h02;
	localparam logic [7:0] INSTR_MODIFY = 8'h05;
	localparam logic [7:0] INSTR_STATUS = 8'ha0;
	localparam logic [7:0] INSTR_RX_STATUS = 8'hb0;
	localparam logic [3:0] OP_RX_READ = 4'h9;
	localparam logic [4:0] OP_TX_LOAD = 5'h08;
	localparam logic [4:0] OP_RTS = 5'h10;

	// Register space
	localparam int REG_DEPTH = 128;
	localparam int IDX_W = 7;
	localparam logic [7:0] ADDR_STAT = 8'h0e;
	localparam logic [7:0] ADDR_CTRL = 8'h0f;
	localparam logic [7:0] ADDR_INTE = 8'h2b;
	localparam logic [7:0] ADDR_INTF = 8'h2c;
	localparam logic [7:0] ADDR_EFLG = 8'h2d;
	localparam logic [7:0] ADDR_PINCTRL = 8'h0c;
	localparam logic [7:0] ADDR_RTSCTRL = 8'h0d;
	localparam logic [7:0] RST_STAT = 8'h80;
	localparam logic [7:0] RST_CTRL = 8'he7;
	localparam logic [7:0] RST_OTHER = 8'h00;
	localparam logic [3:0] ROW_STAT = 4'he;
	localparam logic [3:0] ROW_CTRL = 4'hf;

	// Buffer locations
	localparam logic [7:0] TXB_CTRL0 = 8'h30;
	localparam logic [7:0] RXB_CTRL0 = 8'h60;
	localparam logic [7:0] BUF_ID_OFS = 8'h01;
	localparam logic [7:0] BUF_DATA_OFS = 8'h06;
	localparam int TXB_COUNT = 3;

	// Flag positions
	localparam int TRANSMIT_REQUEST_FLAG_BIT = 3;
	localparam int RXIF_BIT0 = 0;
	localparam int TXIF_BIT0 = 2;
	localparam int OPMODE_LSB = 5;
	localparam logic [2:0] OPMODE_CONFIG = 3'b100;

	// Host timing in system clock cycles
	localparam int HOST_HALF = 4;
	localparam int HOST_GAP = 4;

	// Column/row decode: row E of every column aliases the STAT register and row F the CTRL register
	function automatic logic [IDX_W-1:0] map_idx(input logic [7:0] addr);
		if (addr[3:0] == ROW_STAT || addr[3:0] == ROW_CTRL) begin
			return {3'b000, addr[3:0]};
		end
		return addr[IDX_W-1:0];
	endfunction

	function automatic logic bit_modifiable(input logic [7:0] addr);
		logic [7:0] a;
		a = {addr[7:4], addr[3:0]};
		if (a[3:0] == ROW_CTRL || a[3:0] == ROW_STAT) begin
			return 1'b1;
		end
		return a == ADDR_PINCTRL || a == ADDR_RTSCTRL || a == ADDR_INTE || a == ADDR_INTF ||
			a == ADDR_EFLG || (a[3:0] == 4'h0 && a[7:4] >= 4'h3 && a[7:4] <= 4'h7);
	endfunction

	function automatic logic [7:0] reg_default(input int idx);
		if (idx == int'(ADDR_STAT)) begin
			return RST_STAT;
		end
		if (idx == int'(ADDR_CTRL)) begin
			return RST_CTRL;
		end
		return RST_OTHER;
	endfunction

endpackage

// ### rtl/ccs_spi_if.sv
/*
 SPI link between the host controller and the CAN controller command port.
 Assumes a pull-up on the serial output line while the device does not drive it.
*/
`timescale 1ns/1ps
interface ccs_spi_if;
	logic cs_n;
	logic sck;
	logic si;
	logic so_drv;
	logic so_oe;
	logic so;

	// Released line floats high through the pull-up
	assign so = so_oe ? so_drv : 1'b1;

	modport dev (input cs_n, input sck, input si, output so_drv, output so_oe);
	modport host (output cs_n, output sck, output si, input so);
endinterface

// ### rtl/ccs_sync2.sv
/*
 Two flip-flop level synchroniser, one per bit.
 Assumes each bit is a slow level; multi-bit groups must be quasi-static.
*/
`timescale 1ns/1ps
module ccs_sync2 #(
	parameter int WIDTH = 1
) (
	// Destination clock
	input wire logic i_clk,
	// Levels in and out
	input wire logic [WIDTH-1:0] i_d,
	output logic [WIDTH-1:0] o_q
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge i_clk) begin
		meta_reg <= i_d;
		o_q <= meta_reg;
	end
endmodule

// ### rtl/ccs_dev_end.sv
/*
 Device end of the SPI command port: instruction decoder, register space, serial output
 and end-of-frame flag effects, all clocked by the serial clock. Assumes the host holds
 the serial clock still while chip select is high; summary flags cross to the system clock.
*/
`timescale 1ns/1ps
module ccs_dev_end import ccs_pkg::*; (
	// System side
	input wire logic i_clk_sys,
	input wire logic i_srst,
	// SPI link
	ccs_spi_if.dev spi,
	// Receive status from the CAN engine
	input wire logic [7:0] i_rx_status,
	// Flag view in the system domain
	output logic [TXB_COUNT-1:0] o_tx_request,
	output logic [1:0] o_rx_full,
	output logic o_config_mode,
	output logic o_reset_event
);
	typedef enum logic [3:0] {
		ST_CMD, ST_ADDR, ST_READ, ST_WRITE, ST_MASK, ST_MODIFY, ST_STATUS, ST_RX_STATUS, ST_IDLE
	} ccs_dev_state_e;

	ccs_dev_state_e state_reg;
	logic [2:0] bit_cnt_reg;
	logic [6:0] shift_reg;
	logic [7:0] cmd_reg;
	logic [7:0] ptr_reg;
	logic [7:0] mask_reg;
	logic [7:0] mem_reg [REG_DEPTH];
	logic reset_pend_reg;
	logic rx_clr_pend_reg;
	logic rx_clr_idx_reg;
	logic so_reg;
	logic so_oe_reg;
	logic [6:0] out_sr_reg;
	logic [7:0] rx_byte;
	logic byte_done;
	logic first_edge;
	logic [7:0] tx_byte;
	logic [7:0] status_byte;
	logic [7:0] rx_status_link;
	logic [7:0] intf;
	logic [7:0] mod_mask;
	logic [IDX_W-1:0] ptr_idx;
	logic [9:0] link_flags;
	logic [9:0] sys_flags;
	logic cs_prev_reg;

	assign rx_byte = {shift_reg, spi.si};
	assign byte_done = bit_cnt_reg == 3'd7;
	assign first_edge = state_reg == ST_CMD && bit_cnt_reg == 3'd0;
	assign ptr_idx = map_idx(ptr_reg);
	assign intf = mem_reg[map_idx(ADDR_INTF)];
	assign mod_mask = bit_modifiable(ptr_reg) ? mask_reg : 8'hff;

	// Poll byte assembled from the home registers, so both paths always agree
	always_comb begin
		for (int b = 0; b < TXB_COUNT; b++) begin
			status_byte[2 + 2 * b] = mem_reg[map_idx(8'(TXB_CTRL0 + {2'b00, 2'(b), 4'h0}))][TRANSMIT_REQUEST_FLAG_BIT];
			status_byte[3 + 2 * b] = intf[TXIF_BIT0 + b];
		end
		status_byte[1:0] = intf[RXIF_BIT0 +: 2];
	end

	ccs_sync2 #(.WIDTH(8)) u_rx_status_sync (
		.i_clk(spi.sck),
		.i_d(i_rx_status),
		.o_q(rx_status_link)
	);

	// Frame decoder; chip select high holds it at the instruction byte
	always_ff @(posedge spi.sck or posedge spi.cs_n) begin
		if (spi.cs_n) begin
			state_reg <= ST_CMD;
			bit_cnt_reg <= 3'd0;
			shift_reg <= 7'h00;
			cmd_reg <= 8'h00;
			ptr_reg <= 8'h00;
			mask_reg <= 8'h00;
		end else begin
			bit_cnt_reg <= 3'(bit_cnt_reg + 3'd1);
			shift_reg <= rx_byte[6:0];
			if (byte_done) begin
				case (state_reg)
					ST_CMD: begin
						cmd_reg <= rx_byte;
						state_reg <= ST_IDLE;
						if (rx_byte == INSTR_READ || rx_byte == INSTR_WRITE || rx_byte == INSTR_MODIFY) begin
							state_reg <= ST_ADDR;
						end else if (rx_byte == INSTR_STATUS) begin
							state_reg <= ST_STATUS;
						end else if (rx_byte == INSTR_RX_STATUS) begin
							state_reg <= ST_RX_STATUS;
						end else if (rx_byte[7:4] == OP_RX_READ && !rx_byte[3] && !rx_byte[0]) begin
							ptr_reg <= RXB_CTRL0 + {3'b000, rx_byte[2], 4'h0} +
								(rx_byte[1] ? BUF_DATA_OFS : BUF_ID_OFS);
							state_reg <= ST_READ;
						end else if (rx_byte[7:3] == OP_TX_LOAD && rx_byte[2:1] != 2'b11) begin
							ptr_reg <= TXB_CTRL0 + {2'b00, rx_byte[2:1], 4'h0} +
								(rx_byte[0] ? BUF_DATA_OFS : BUF_ID_OFS);
							state_reg <= ST_WRITE;
						end
					end
					ST_ADDR: begin
						ptr_reg <= rx_byte;
						if (cmd_reg == INSTR_READ) begin
							state_reg <= ST_READ;
						end else if (cmd_reg == INSTR_WRITE) begin
							state_reg <= ST_WRITE;
						end else begin
							state_reg <= ST_MASK;
						end
					end
					ST_READ: ptr_reg <= 8'(ptr_reg + 8'h01);
					ST_WRITE: ptr_reg <= 8'(ptr_reg + 8'h01);
					ST_MASK: begin
						mask_reg <= rx_byte;
						state_reg <= ST_MODIFY;
					end
					ST_MODIFY: state_reg <= ST_IDLE;
					default: state_reg <= state_reg;
				endcase
			end
		end
	end

	// Select-rise effects wait for the next frame's first edge, as the serial clock is stopped
	// between frames; nothing reads the space before the instruction byte completes.
	always_ff @(posedge spi.sck or posedge i_srst) begin
		if (i_srst) begin
			for (int i = 0; i < REG_DEPTH; i++) begin
				mem_reg[i] <= reg_default(i);
			end
		end else if (first_edge && reset_pend_reg) begin
			for (int i = 0; i < REG_DEPTH; i++) begin
				mem_reg[i] <= reg_default(i);
			end
		end else begin
			if (first_edge && rx_clr_pend_reg) begin
				mem_reg[map_idx(ADDR_INTF)][RXIF_BIT0 + int'(rx_clr_idx_reg)] <= 1'b0;
			end
			// Only whole bytes reach the space; a short final byte never commits
			if (byte_done && state_reg == ST_WRITE && !ptr_reg[7]) begin
				mem_reg[ptr_idx] <= rx_byte;
			end
			if (byte_done && state_reg == ST_MODIFY && !ptr_reg[7]) begin
				mem_reg[ptr_idx] <= (mem_reg[ptr_idx] & ~mod_mask) | (rx_byte & mod_mask);
			end
			if (byte_done && state_reg == ST_CMD && rx_byte[7:3] == OP_RTS) begin
				for (int b = 0; b < TXB_COUNT; b++) begin
					if (rx_byte[b]) begin
						mem_reg[map_idx(8'(TXB_CTRL0 + {2'b00, 2'(b), 4'h0}))][TRANSMIT_REQUEST_FLAG_BIT] <= 1'b1;
					end
				end
			end
		end
	end

	// Pending select-rise effects
	always_ff @(posedge spi.sck or posedge i_srst) begin
		if (i_srst) begin
			reset_pend_reg <= 1'b0;
			rx_clr_pend_reg <= 1'b0;
			rx_clr_idx_reg <= 1'b0;
		end else begin
			if (first_edge) begin
				reset_pend_reg <= 1'b0;
				rx_clr_pend_reg <= 1'b0;
			end
			if (byte_done && state_reg == ST_CMD && rx_byte == INSTR_RESET) begin
				reset_pend_reg <= 1'b1;
			end
			if (byte_done && state_reg == ST_CMD && rx_byte[7:4] == OP_RX_READ && !rx_byte[3] && !rx_byte[0]) begin
				rx_clr_pend_reg <= 1'b1;
				rx_clr_idx_reg <= rx_byte[2];
			end
		end
	end

	always_comb begin
		case (state_reg)
			ST_READ: tx_byte = ptr_reg[7] ? 8'h00 : mem_reg[ptr_idx];
			ST_STATUS: tx_byte = status_byte;
			ST_RX_STATUS: tx_byte = rx_status_link;
			default: tx_byte = 8'h00;
		endcase
	end

	// Serial output, shifted on falling edges
	always_ff @(negedge spi.sck or posedge spi.cs_n) begin
		if (spi.cs_n) begin
			so_reg <= 1'b1;
			so_oe_reg <= 1'b0;
			out_sr_reg <= 7'h00;
		end else if (bit_cnt_reg == 3'd0 &&
			(state_reg == ST_READ || state_reg == ST_STATUS || state_reg == ST_RX_STATUS)) begin
			so_reg <= tx_byte[7];
			out_sr_reg <= tx_byte[6:0];
			so_oe_reg <= 1'b1;
		end else begin
			so_reg <= out_sr_reg[6];
			out_sr_reg <= {out_sr_reg[5:0], 1'b0};
		end
	end
	assign spi.so_drv = so_reg;
	assign spi.so_oe = so_oe_reg;

	// Slow levels for the system domain; stable whenever select is high
	always_comb begin
		link_flags[0] = spi.cs_n;
		link_flags[3:1] = {status_byte[6], status_byte[4], status_byte[2]};
		link_flags[5:4] = status_byte[1:0];
		link_flags[6] = mem_reg[map_idx(ADDR_STAT)][OPMODE_LSB +: 3] == OPMODE_CONFIG;
		link_flags[7] = reset_pend_reg;
		link_flags[8] = rx_clr_pend_reg;
		link_flags[9] = rx_clr_idx_reg;
	end

	ccs_sync2 #(.WIDTH(10)) u_sys_sync (
		.i_clk(i_clk_sys),
		.i_d(link_flags),
		.o_q(sys_flags)
	);

	// Pending effects show once select is high; outputs hold until the next frame lands them
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			cs_prev_reg <= 1'b1;
			o_tx_request <= '0;
			o_rx_full <= 2'b00;
			o_config_mode <= 1'b1;
			o_reset_event <= 1'b0;
		end else begin
			cs_prev_reg <= sys_flags[0];
			o_reset_event <= sys_flags[0] && !cs_prev_reg && sys_flags[7];
			if (sys_flags[0] && sys_flags[7]) begin
				o_tx_request <= '0;
				o_rx_full <= 2'b00;
				o_config_mode <= 1'b1;
			end else if (sys_flags[0] || !(sys_flags[7] || sys_flags[8])) begin
				o_tx_request <= sys_flags[3:1];
				o_rx_full <= sys_flags[5:4] & ~((sys_flags[0] && sys_flags[8]) ?
					(sys_flags[9] ? 2'b10 : 2'b01) : 2'b00);
				o_config_mode <= sys_flags[6];
			end
		end
	end
endmodule

// ### rtl/ccs_host_end.sv
/*
 Host end: SPI master in mode 0 that frames user bytes into commands.
 Assumes the user marks the last byte of each command; the serial clock is
 divided from the system clock, so the serial input passes a synchroniser.
*/
`timescale 1ns/1ps
module ccs_host_end import ccs_pkg::*; #(
	parameter int HALF = HOST_HALF,
	parameter int GAP = HOST_GAP
) (
	// System side
	input wire logic i_clk_sys,
	input wire logic i_srst,
	// SPI link
	ccs_spi_if.host spi,
	// Command bytes in
	input wire logic i_cmd_valid,
	input wire logic [7:0] i_cmd_data,
	input wire logic i_cmd_last,
	output logic o_cmd_ready,
	// Bytes returned
	output logic o_rsp_valid,
	output logic [7:0] o_rsp_data,
	output logic o_init_done
);
	typedef enum logic [2:0] {H_GAP, H_IDLE, H_LOW, H_HIGH, H_NEXT} ccs_host_state_e;

	ccs_host_state_e state_reg;
	logic cs_n_reg;
	logic sck_reg;
	logic si_reg;
	logic [7:0] tx_sr_reg;
	logic [6:0] rx_sr_reg;
	logic [2:0] bit_cnt_reg;
	logic [7:0] div_reg;
	logic last_reg;
	logic boot_reg;
	logic so_sync;
	logic take;

	ccs_sync2 #(.WIDTH(1)) u_so_sync (
		.i_clk(i_clk_sys),
		.i_d(spi.so),
		.o_q(so_sync)
	);

	assign spi.cs_n = cs_n_reg;
	assign spi.sck = sck_reg;
	assign spi.si = si_reg;
	assign take = i_cmd_valid && o_cmd_ready;

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			state_reg <= H_GAP;
			cs_n_reg <= 1'b1;
			sck_reg <= 1'b0;
			si_reg <= 1'b0;
			tx_sr_reg <= 8'h00;
			rx_sr_reg <= 7'h00;
			bit_cnt_reg <= 3'd0;
			div_reg <= 8'h00;
			last_reg <= 1'b0;
			boot_reg <= 1'b1;
			o_cmd_ready <= 1'b0;
			o_rsp_valid <= 1'b0;
			o_rsp_data <= 8'h00;
			o_init_done <= 1'b0;
		end else begin
			o_rsp_valid <= 1'b0;
			div_reg <= 8'(div_reg + 8'h01);
			case (state_reg)
				H_GAP: begin
					if (div_reg == 8'(GAP - 1)) begin
						div_reg <= 8'h00;
						if (boot_reg) begin
							// Power-on reset frame before any user command
							boot_reg <= 1'b0;
							tx_sr_reg <= INSTR_RESET;
							si_reg <= INSTR_RESET[7];
							last_reg <= 1'b1;
							cs_n_reg <= 1'b0;
							state_reg <= H_LOW;
						end else begin
							o_init_done <= 1'b1;
							o_cmd_ready <= 1'b1;
							state_reg <= H_IDLE;
						end
					end
				end
				H_IDLE, H_NEXT: begin
					div_reg <= 8'h00;
					if (take) begin
						tx_sr_reg <= i_cmd_data;
						si_reg <= i_cmd_data[7];
						last_reg <= i_cmd_last;
						cs_n_reg <= 1'b0;
						bit_cnt_reg <= 3'd0;
						o_cmd_ready <= 1'b0;
						state_reg <= H_LOW;
					end
				end
				H_LOW: begin
					if (div_reg == 8'(HALF - 1)) begin
						div_reg <= 8'h00;
						sck_reg <= 1'b1;
						state_reg <= H_HIGH;
					end
				end
				H_HIGH: begin
					// Output settled since the previous falling edge, well past the synchroniser
					if (div_reg == 8'(HALF - 1)) begin
						div_reg <= 8'h00;
						sck_reg <= 1'b0;
						rx_sr_reg <= {rx_sr_reg[5:0], so_sync};
						bit_cnt_reg <= 3'(bit_cnt_reg + 3'd1);
						if (bit_cnt_reg == 3'd7) begin
							o_rsp_valid <= 1'b1;
							o_rsp_data <= {rx_sr_reg, so_sync};
							if (last_reg) begin
								cs_n_reg <= 1'b1;
								state_reg <= H_GAP;
							end else begin
								o_cmd_ready <= 1'b1;
								state_reg <= H_NEXT;
							end
						end else begin
							si_reg <= tx_sr_reg[6];
							tx_sr_reg <= {tx_sr_reg[6:0], 1'b0};
							state_reg <= H_LOW;
						end
					end
				end
				default: state_reg <= H_GAP;
			endcase
		end
	end
endmodule

// ### testbench/ccs_link_sva.sv
/*
 Checker on the SPI link between host end and device end.
 Assumes the host end runs with its default half period and gap.
*/
`timescale 1ns/1ps
module ccs_link_chk (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_srst,
	// Link
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic so_drv,
	input wire logic so_oe,
	input wire logic so
);
	logic sck_q;
	logic [2:0] bit_cnt;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	always_ff @(posedge i_clk_sys) begin
		sck_q <= sck;
	end
	// Rising clock edges in the frame, modulo one byte
	always_ff @(posedge i_clk_sys) begin
		if (i_srst || cs_n) begin
			bit_cnt <= 3'h0;
		end else if (sck && !sck_q) begin
			bit_cnt <= bit_cnt + 3'h1;
		end
	end
	sequence s_setup;
		!sck [*4] ##1 sck;
	endsequence
	sequence s_high;
		sck [*3] ##1 !sck;
	endsequence
	AST_IDLE_LOW: assert property (cs_n |-> !sck) else $error("clock moves outside frame");
	AST_SETUP: assert property ($fell(cs_n) |-> s_setup) else $error("first clock edge early");
	AST_HIGH: assert property ($rose(sck) |=> s_high) else $error("clock high phase wrong");
	AST_SI_HOLD: assert property (sck |-> $stable(si)) else $error("input data moved with clock high");
	AST_SO_ON_FALL: assert property (sck |-> $stable(so_drv)) else $error("output data moved with clock high");
	AST_WHOLE_BYTES: assert property ($rose(cs_n) |-> bit_cnt == 3'h0) else $error("frame ended mid byte");
	AST_OE_ALIGN: assert property ($rose(so_oe) |-> bit_cnt == 3'h0 && !sck) else $error("output enabled mid byte");
	AST_OE_RELEASE: assert property (cs_n && $past(cs_n) |-> !so_oe) else $error("output driven outside frame");
	AST_GAP: assert property ($rose(cs_n) |-> cs_n [*4]) else $error("select gap too short");
	AST_SO_RELEASED: assert property (cs_n |-> so) else $error("output line not released outside frame");
endmodule

// ### testbench/test_can_ctrl_spi_command_port.sv
/*
 Testbench joining host end and device end over the SPI link.
 Assumes the device sets no receive flags itself; the bench writes them.
*/
`timescale 1ns/1ps
module test_can_ctrl_spi_command_port;
	import ccs_pkg::*;
	logic i_clk_sys;
	logic i_srst;
	logic cmd_valid;
	logic [7:0] cmd_data;
	logic cmd_last;
	logic cmd_ready;
	logic rsp_valid;
	logic [7:0] rsp_data;
	logic init_done;
	logic [7:0] rx_status;
	logic [TXB_COUNT-1:0] tx_request;
	logic [1:0] rx_full;
	logic config_mode;
	logic reset_event;
	int num_errors = 0;
	int num_checks = 0;
	int cycles = 0;
	int resets = 0;
	integer seed = 32'h4fbb;
	logic [7:0] mem [0:255];
	logic [7:0] tb_tx [0:7];
	logic [7:0] tb_rx [0:7];
	ccs_spi_if spi_if();
	ccs_dev_end ccs_dev_end_inst(.i_clk_sys(i_clk_sys), .i_srst(i_srst), .spi(spi_if), .i_rx_status(rx_status),
		.o_tx_request(tx_request), .o_rx_full(rx_full), .o_config_mode(config_mode), .o_reset_event(reset_event));
	ccs_host_end ccs_host_end_inst(.i_clk_sys(i_clk_sys), .i_srst(i_srst), .spi(spi_if), .i_cmd_valid(cmd_valid),
		.i_cmd_data(cmd_data), .i_cmd_last(cmd_last), .o_cmd_ready(cmd_ready), .o_rsp_valid(rsp_valid),
		.o_rsp_data(rsp_data), .o_init_done(init_done));
	ccs_link_chk ccs_link_chk_inst(.i_clk_sys(i_clk_sys), .i_srst(i_srst), .cs_n(spi_if.cs_n), .sck(spi_if.sck),
		.si(spi_if.si), .so_drv(spi_if.so_drv), .so_oe(spi_if.so_oe), .so(spi_if.so));
	initial begin
		i_clk_sys = 1'b0;
		forever #2.5 i_clk_sys = ~i_clk_sys;
	end
	// Cuts a hang short; the ceiling is several times the expected run
	always @(posedge i_clk_sys) begin
		cycles++;
		if (reset_event === 1'b1) resets++;
		if (cycles == 40000) begin
			num_errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic mem_defaults();
		for (int i = 0; i < 256; i++) mem[i] = (i % 16 == 14) ? 8'h80 : (i % 16 == 15) ? 8'he7 : 8'h00;
	endtask
	// One command of n bytes; the offer is held until the edge that takes it
	task automatic frame(input int n);
		for (int i = 0; i < n; i++) begin
			cmd_valid <= 1'b1;
			cmd_data <= tb_tx[i];
			cmd_last <= (i == n - 1);
			@(posedge i_clk_sys);
			while (cmd_ready !== 1'b1) @(posedge i_clk_sys);
			cmd_valid <= 1'b0;
			@(posedge i_clk_sys);
			while (rsp_valid !== 1'b1) @(posedge i_clk_sys);
			tb_rx[i] = rsp_data;
		end
		repeat (8) @(posedge i_clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		{tb_tx[0], tb_tx[1], tb_tx[2]} = {INSTR_WRITE, a, d};
		mem[a] = d;
		frame(3);
	endtask
	task automatic rd_chk(input logic [7:0] a, input int n);
		{tb_tx[0], tb_tx[1]} = {INSTR_READ, a};
		frame(n + 2);
		for (int i = 0; i < n; i++) check("register read", tb_rx[i + 2], mem[a + 8'(i)]);
	endtask
	task automatic modify(input logic [7:0] a, input logic [7:0] m, input logic [7:0] d, input logic bitwise);
		{tb_tx[0], tb_tx[1], tb_tx[2], tb_tx[3]} = {INSTR_MODIFY, a, m, d};
		mem[a] = bitwise ? ((mem[a] & ~m) | (d & m)) : d;
		frame(4);
		rd_chk(a, 1);
	endtask
	initial begin
		logic [7:0] a;
		logic [2:0] acc;
		logic [1:0] full;
		i_srst = 1'b1;
		cmd_valid = 1'b0;
		cmd_data = 8'h00;
		cmd_last = 1'b0;
		rx_status = 8'h00;
		mem_defaults();
		repeat (8) @(posedge i_clk_sys);
		i_srst <= 1'b0;
		while (init_done !== 1'b1) @(posedge i_clk_sys);
		repeat (8) @(posedge i_clk_sys);
		check("boot reset events", 8'(resets), 8'h01);
		check("config mode", {7'h00, config_mode}, 8'h01);
		rd_chk(8'h0d, 3);
		rd_chk(8'h2e, 1);
		for (int k = 0; k < 4; k++) begin
			a = 8'h31 + {5'h00, 3'($random(seed))};
			{tb_tx[0], tb_tx[1]} = {INSTR_WRITE, a};
			for (int i = 0; i < 3; i++) begin
				tb_tx[i + 2] = 8'($random(seed));
				mem[a + 8'(i)] = tb_tx[i + 2];
			end
			frame(5);
			rd_chk(a, 3);
		end
		for (int abc = 0; abc < 6; abc++) begin
			a = 8'h31 + 8'h10 * 8'(abc / 2) + (abc[0] ? 8'h05 : 8'h00);
			{tb_tx[0], tb_tx[1]} = {8'h40 | 8'(abc), 8'($random(seed))};
			mem[a] = tb_tx[1];
			frame(2);
			rd_chk(a, 1);
		end
		wr(ADDR_INTE, 8'h0f);
		modify(ADDR_INTE, 8'h00, 8'hff, 1'b1);
		for (int k = 0; k < 3; k++) modify(ADDR_INTE, 8'($random(seed)), 8'($random(seed)), 1'b1);
		modify(8'h35, 8'h0f, 8'($random(seed)), 1'b0);
		acc = 3'b000;
		for (int n = 0; n < 8; n++) begin
			tb_tx[0] = 8'h80 | 8'(n);
			frame(1);
			acc = acc | 3'(n);
			check("transmit requests", {5'h00, tx_request}, {5'h00, acc});
		end
		for (int b = 0; b < 3; b++) begin
			mem[8'h30 + 8'h10 * 8'(b)] = 8'h08;
			rd_chk(8'h30 + 8'h10 * 8'(b), 1);
		end
		wr(ADDR_INTF, 8'h03);
		for (int i = 0; i < 4; i++) wr(8'h61 + 8'h10 * 8'(i / 2) + (i[0] ? 8'h05 : 8'h00), 8'($random(seed)));
		full = 2'b11;
		check("rx full flags", {6'h00, rx_full}, 8'h03);
		for (int nm = 0; nm < 4; nm++) begin
			a = 8'h61 + 8'h10 * 8'(nm / 2) + (nm[0] ? 8'h05 : 8'h00);
			tb_tx[0] = 8'h90 | 8'(nm << 1);
			frame(3);
			check("rx buffer read", tb_rx[1], mem[a]);
			check("rx buffer next", tb_rx[2], mem[a + 8'h01]);
			full[nm / 2] = 1'b0;
			check("rx full after read", {6'h00, rx_full}, {6'h00, full});
		end
		tb_tx[0] = INSTR_STATUS;
		frame(3);
		check("status poll", tb_rx[1], {1'b0, acc[2], 1'b0, acc[1], 1'b0, acc[0], full});
		check("status poll repeat", tb_rx[2], tb_rx[1]);
		for (int k = 0; k < 2; k++) begin
			a = 8'($random(seed));
			rx_status <= a;
			repeat (10) @(posedge i_clk_sys);
			tb_tx[0] = INSTR_RX_STATUS;
			frame(3);
			check("rx status", tb_rx[1], a);
			check("rx status repeat", tb_rx[2], a);
		end
		wr(ADDR_STAT, 8'h00);
		check("config left", {7'h00, config_mode}, 8'h00);
		tb_tx[0] = INSTR_RESET;
		frame(1);
		mem_defaults();
		check("reset events", 8'(resets), 8'h02);
		check("requests after reset", {5'h00, tx_request}, 8'h00);
		check("config after reset", {7'h00, config_mode}, 8'h01);
		rd_chk(8'h30, 8);
		rd_chk(ADDR_STAT, 2);
		complete_run();
	end
endmodule
